// >>> shared/coax_pkg.sv
// Constants and types shared by the coaxial backup switch control logic
// Notes on behaviour
// RULE1: Unpowered relays leave every output on its own primary input.
// RULE2: Each output always has exactly one source selected.
// RULE3: Dedicated-mode backup selects dedicated input and terminates the primary.
// RULE4: A dedicated backup input not in use is terminated.
// RULE5: Shared-mode backup routes the shared input and terminates the primary.
// RULE6: Shared input is routed only in shared mode, otherwise terminated.
// RULE7: Paired mode gangs section 1 with 3 and section 2 with 4; commands to sections 3 and 4 act alone.
// RULE8: Green indicator lit while the primary input feeds the output.
// RULE9: Red indicator lit while the dedicated backup feeds the output.
// RULE10: Shared input lamp lit and served output indicator blinks.
// RULE11: Higher priority request takes the shared input from the holder.
// RULE12: Priority order loads only from the remote controller port.
// RULE13: Priority order resets to section 1 highest through section 4 lowest.
// RULE14: Error lights the error lamp and sounds the beeper if enabled.
// RULE15: Any mode change releases all backups back to primary inputs.
// RULE16: Dedicated-mode key toggles dedicated and paired; lamp steady or flashing.
// RULE17: Displaced holder returns to primary; lower priority cannot displace.
// RULE18: Old source is broken before the new one is made.
package coax_pkg;
	localparam int NSEC = 4;
	typedef enum logic [1:0] {RT_PRI = 2'b00, RT_DED = 2'b01, RT_SHR = 2'b11} route_e;
	typedef enum logic [1:0] {MD_DED = 2'b00, MD_PAIR = 2'b01, MD_SHR = 2'b11} mode_e;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD  = 8'h04;
	localparam logic [7:0] OFS_PRIO = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQS = 8'h10;
	localparam logic [7:0] OFS_IRQM = 8'h14;
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_BEEP_BIT = 2;
	localparam int CMD_SEC_LSB   = 0;
	localparam int CMD_BKUP_BIT  = 4;
	localparam int STAT_HOLD_LSB = 8;
	localparam int STAT_HV_BIT   = 10;
	localparam int IRQ_ERR  = 0;
	localparam int IRQ_PRE  = 1;
	localparam int IRQ_REF  = 2;
	localparam int IRQ_MODE = 3;
	localparam int NIRQ     = 4;
	// Reset values; priority holds a 2-bit rank per section, 0 is highest
	localparam logic [7:0] PRIO_RST = 8'hE4;
	localparam mode_e      MODE_RST = MD_DED;
	localparam logic       BEEP_RST = 1'b1;
	localparam logic [3:0] MASK_RST = 4'h0;
	// Timing
	localparam int CLK_HZ          = 200_000_000;
	localparam int TICK_MS         = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int BLINK_HALF_MS   = 250;
	localparam int BEEP_MS         = 500;
endpackage : coax_pkg

// >>> shared/route_if.sv
// Route targets and applied relay state between controller and sequencer
`timescale 1ns/1ps
`default_nettype none
interface route_if;
	coax_pkg::route_e [3:0] tgt;
	coax_pkg::route_e [3:0] app;
	logic [3:0]             rly_ded;
	logic [3:0]             rly_shr;
	logic [3:0]             term_pri;
	logic [3:0]             term_ded;
	logic                   term_shr;
	modport ctl (output tgt, input app, rly_ded, rly_shr, term_pri, term_ded, term_shr);
	modport seq (input tgt, output app, rly_ded, rly_shr, term_pri, term_ded, term_shr);
endinterface : route_if
`default_nettype wire

// >>> verilog/relay_seq.sv
// Break-before-make relay sequencer for the four switch sections
`timescale 1ns/1ps
`default_nettype none
module relay_seq (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Targets in, relay drive out
	route_if.seq      rt
);
	typedef struct packed {
		coax_pkg::route_e [3:0] app;
		logic [3:0]             rd;
		logic [3:0]             rs;
		logic [3:0]             tp;
		logic [3:0]             td;
		logic                   ts;
	} seq_s;
	seq_s q, d;
	logic shr_used;

	// A changing section passes through its primary input for one cycle, so the
	// output never sees two sources and the shared input is freed before reuse
	always_comb
	begin
		d = q;
		shr_used = 1'b0;
		for (int s = 0; s < 4; s++)
			shr_used = shr_used | (q.app[s] == coax_pkg::RT_SHR);
		for (int s = 0; s < 4; s++)
		begin
			if (q.app[s] != rt.tgt[s])
			begin
				if (q.app[s] != coax_pkg::RT_PRI)
					d.app[s] = coax_pkg::RT_PRI; // RULE18
				else if (rt.tgt[s] != coax_pkg::RT_SHR || !shr_used)
					d.app[s] = rt.tgt[s]; // RULE3 RULE5
			end
		end
		d.ts = 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			d.rd[s] = d.app[s] == coax_pkg::RT_DED;
			d.rs[s] = d.app[s] == coax_pkg::RT_SHR;
			d.tp[s] = d.app[s] != coax_pkg::RT_PRI; // RULE3 RULE5
			d.td[s] = d.app[s] != coax_pkg::RT_DED; // RULE4
			if (d.rs[s])
				d.ts = 1'b0; // RULE6
		end
	end

	// All coils off after reset: the unpowered routing
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q <= '{app: {4{coax_pkg::RT_PRI}}, rd: 4'h0, rs: 4'h0, tp: 4'h0, td: 4'hF, ts: 1'b1}; // RULE1
		else
			q <= d;
	end

	assign rt.app      = q.app;
	assign rt.rly_ded  = q.rd;
	assign rt.rly_shr  = q.rs;
	assign rt.term_pri = q.tp;
	assign rt.term_ded = q.td;
	assign rt.term_shr = q.ts;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	one_source_a: assert property (!(|(q.rd & q.rs))) // RULE2
		else $error("output fed by two backups");
	break_first_a: assert property (q.app[0] != coax_pkg::RT_PRI && q.app[0] != $past(q.app[0])
		|-> $past(q.app[0]) == coax_pkg::RT_PRI) // RULE18
		else $error("section 1 switched without break");
	shr_single_a: assert property ($onehot0(q.rs)) // RULE5
		else $error("shared input on two outputs");
	ded_term_a: assert property (q.td == ~q.rd) // RULE4
		else $error("dedicated termination wrong");
endmodule : relay_seq
`default_nettype wire

// >>> verilog/coax_backup_switch.sv
// Control of the four-section coaxial backup switch with register port
`timescale 1ns/1ps
`default_nettype none
module coax_backup_switch #(
	parameter int unsigned TICK_CYCLES = coax_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Remote controller register port
	input  wire logic [7:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [31:0]     rdata,
	// Front panel keys, one-cycle pulses
	input  wire logic [3:0] key_normal,
	input  wire logic [3:0] key_backup,
	input  wire logic       key_ded_mode,
	input  wire logic       key_shr_mode,
	// Monitoring
	input  wire logic       err_in,
	// Relay drive and terminations
	output logic [3:0]      relay_ded,
	output logic [3:0]      relay_shr,
	output logic [3:0]      term_primary,
	output logic [3:0]      term_dedicated,
	output logic            term_shared,
	// Indicators
	output logic [3:0]      led_green,
	output logic [3:0]      led_red,
	output logic            led_shared,
	output logic            lamp_ded_key,
	output logic            lamp_shr_key,
	output logic            led_error,
	output logic            beeper,
	// Interrupt
	output logic            irq
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	initial
	begin
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
	end

	typedef struct packed {
		coax_pkg::mode_e        mode;
		logic                   beep_en;
		logic [7:0]             prio;
		coax_pkg::route_e [3:0] tgt;
		logic [1:0]             hold;
		logic                   hv;
		logic                   ev_pre;
		logic                   ev_ref;
		logic                   ev_mode;
		logic [3:0]             irqs;
		logic [3:0]             irqm;
		logic [31:0]            rdata;
		logic [TW-1:0]          tick;
		logic [8:0]             blink_ms;
		logic                   blink;
		logic [8:0]             beep_ms;
		logic                   err_prev;
		logic [3:0]             green;
		logic [3:0]             red;
		logic                   shr_led;
		logic                   ded_lamp;
		logic                   shr_lamp;
		logic                   err_led;
		logic                   beep;
		logic                   irq;
	} ctl_s;
	ctl_s q, d;

	route_if rt ();

	relay_seq u_seq (
		.clk  (clk),
		.rstn (rstn),
		.rt   (rt.seq)
	);

	// Rank of a section in the packed priority order
	function automatic logic [1:0] rank(input logic [7:0] p, input logic [1:0] s);
		return p[2*s +: 2];
	endfunction : rank

	// A priority order is usable only if every rank is held once
	function automatic logic perm_ok(input logic [7:0] p);
		logic [3:0] seen;
		seen = 4'h0;
		for (int s = 0; s < 4; s++)
			seen[rank(p, 2'(s))] = 1'b1;
		return seen == 4'hF;
	endfunction : perm_ok

	// Any real mode change drops every backup connection
	function automatic ctl_s set_mode(input ctl_s st, input coax_pkg::mode_e m);
		ctl_s r;
		r = st;
		if (m != st.mode)
		begin
			r.mode = m;
			r.tgt = {4{coax_pkg::RT_PRI}}; // RULE15
			r.hv = 1'b0;
			r.ev_mode = 1'b1;
		end
		return r;
	endfunction : set_mode

	// Backup or normal request for one addressed section
	function automatic ctl_s do_cmd(input ctl_s st, input logic [1:0] sec, input logic bk);
		ctl_s       r;
		logic [3:0] m;
		r = st;
		m = 4'h0;
		m[sec] = 1'b1;
		if (st.mode == coax_pkg::MD_PAIR && !sec[1])
			m[sec + 2'd2] = 1'b1; // RULE7
		for (int t = 0; t < 4; t++)
		begin
			if (m[t])
			begin
				if (!bk)
				begin
					r.tgt[t] = coax_pkg::RT_PRI;
					if (r.hv && r.hold == 2'(t))
						r.hv = 1'b0;
				end
				else if (r.mode != coax_pkg::MD_SHR)
					r.tgt[t] = coax_pkg::RT_DED; // RULE3
				else if (!r.hv)
				begin
					r.tgt[t] = coax_pkg::RT_SHR; // RULE5
					r.hold = 2'(t);
					r.hv = 1'b1;
				end
				else if (r.hold != 2'(t))
				begin
					if (rank(r.prio, 2'(t)) < rank(r.prio, r.hold))
					begin
						r.tgt[r.hold] = coax_pkg::RT_PRI; // RULE11 RULE17
						r.tgt[t] = coax_pkg::RT_SHR;
						r.hold = 2'(t);
						r.ev_pre = 1'b1;
					end
					else
						r.ev_ref = 1'b1; // RULE17
				end
			end
		end
		return r;
	endfunction : do_cmd

	// Next state: register port, keys, timers, indicators
	always_comb
	begin
		logic [3:0]  ev;
		logic        ms;
		logic [31:0] stat;
		ev = 4'h0;
		ms = 1'b0;
		stat = 32'h0000_0000;
		d = q;
		d.ev_pre = 1'b0;
		d.ev_ref = 1'b0;
		d.ev_mode = 1'b0;
		// Mode keys and remote mode writes
		if (key_ded_mode)
			d = set_mode(d, q.mode == coax_pkg::MD_DED ? coax_pkg::MD_PAIR : coax_pkg::MD_DED); // RULE16
		else if (key_shr_mode)
			d = set_mode(d, coax_pkg::MD_SHR);
		else if (wr && addr == coax_pkg::OFS_CTRL)
		begin
			d.beep_en = wdata[coax_pkg::CTRL_BEEP_BIT];
			if (wdata[coax_pkg::CTRL_MODE_LSB +: 2] != 2'b10)
				d = set_mode(d, coax_pkg::mode_e'(wdata[coax_pkg::CTRL_MODE_LSB +: 2]));
		end
		// Priority loads only from the register port; keys have no path here
		if (wr && addr == coax_pkg::OFS_PRIO)
		begin
			if (perm_ok(wdata[7:0]))
				d.prio = wdata[7:0]; // RULE12
			else
				d.ev_ref = 1'b1;
		end
		// Section commands; keys in section order, then the remote command
		for (int s = 0; s < 4; s++)
		begin
			if (key_backup[s])
				d = do_cmd(d, 2'(s), 1'b1);
			if (key_normal[s])
				d = do_cmd(d, 2'(s), 1'b0);
		end
		if (wr && addr == coax_pkg::OFS_CMD)
			d = do_cmd(d, wdata[coax_pkg::CMD_SEC_LSB +: 2], wdata[coax_pkg::CMD_BKUP_BIT]);
		// Millisecond enable, blink phase and beeper length
		if (q.tick == TW'(TICK_CYCLES - 1))
		begin
			d.tick = '0;
			ms = 1'b1;
		end
		else
			d.tick = q.tick + TW'(1);
		if (ms)
		begin
			if (q.blink_ms == 9'(coax_pkg::BLINK_HALF_MS - 1))
			begin
				d.blink_ms = 9'h000;
				d.blink = !q.blink;
			end
			else
				d.blink_ms = q.blink_ms + 9'h001;
			if (q.beep_ms != 9'h000)
				d.beep_ms = q.beep_ms - 9'h001;
		end
		d.err_prev = err_in;
		if (err_in && !q.err_prev && q.beep_en)
			d.beep_ms = 9'(coax_pkg::BEEP_MS); // RULE14
		// Events; set wins over a write-one clear in the same cycle
		ev[coax_pkg::IRQ_ERR] = err_in && !q.err_prev;
		ev[coax_pkg::IRQ_PRE] = q.ev_pre;
		ev[coax_pkg::IRQ_REF] = q.ev_ref;
		ev[coax_pkg::IRQ_MODE] = q.ev_mode;
		if (wr && addr == coax_pkg::OFS_IRQS)
			d.irqs = q.irqs & ~wdata[3:0];
		if (wr && addr == coax_pkg::OFS_IRQM)
			d.irqm = wdata[3:0];
		d.irqs = d.irqs | ev;
		d.irq = |(d.irqs & d.irqm);
		// Status word: applied routes, shared holder
		for (int s = 0; s < 4; s++)
			stat[2*s +: 2] = rt.app[s];
		stat[coax_pkg::STAT_HOLD_LSB +: 2] = q.hold;
		stat[coax_pkg::STAT_HV_BIT] = q.hv;
		// Read data stand only in the cycle after the strobe
		d.rdata = 32'h0000_0000;
		if (rd)
		begin
			unique case (addr)
				coax_pkg::OFS_CTRL: d.rdata = {29'h0000_0000, q.beep_en, q.mode};
				coax_pkg::OFS_PRIO: d.rdata = {24'h00_0000, q.prio};
				coax_pkg::OFS_STAT: d.rdata = stat;
				coax_pkg::OFS_IRQS: d.rdata = {28'h000_0000, q.irqs};
				coax_pkg::OFS_IRQM: d.rdata = {28'h000_0000, q.irqm};
				default:            d.rdata = 32'h0000_0000;
			endcase
		end
		// Section indicators follow the applied relays, not the targets; key lamps follow the mode
		d.shr_led = 1'b0;
		for (int s = 0; s < 4; s++)
		begin
			d.green[s] = rt.app[s] == coax_pkg::RT_PRI; // RULE8
			d.red[s] = rt.app[s] == coax_pkg::RT_DED // RULE9
				|| (rt.app[s] == coax_pkg::RT_SHR && q.blink); // RULE10
			if (rt.app[s] == coax_pkg::RT_SHR)
				d.shr_led = 1'b1; // RULE10
		end
		d.ded_lamp = q.mode == coax_pkg::MD_DED || (q.mode == coax_pkg::MD_PAIR && q.blink); // RULE16
		d.shr_lamp = q.mode == coax_pkg::MD_SHR;
		d.err_led = err_in; // RULE14
		d.beep = d.beep_ms != 9'h000;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.mode <= coax_pkg::MODE_RST;
			q.beep_en <= coax_pkg::BEEP_RST;
			q.prio <= coax_pkg::PRIO_RST; // RULE13
			q.tgt <= {4{coax_pkg::RT_PRI}}; // RULE1
			q.irqm <= coax_pkg::MASK_RST;
			q.green <= 4'hF;
			q.ded_lamp <= 1'b1;
		end
		else
			q <= d;
	end

	assign rt.tgt = q.tgt;

	// Outputs straight from flip-flops
	assign rdata          = q.rdata;
	assign relay_ded      = rt.rly_ded;
	assign relay_shr      = rt.rly_shr;
	assign term_primary   = rt.term_pri;
	assign term_dedicated = rt.term_ded;
	assign term_shared    = rt.term_shr;
	assign led_green      = q.green;
	assign led_red        = q.red;
	assign led_shared     = q.shr_led;
	assign lamp_ded_key   = q.ded_lamp;
	assign lamp_shr_key   = q.shr_lamp;
	assign led_error      = q.err_led;
	assign beeper         = q.beep;
	assign irq            = q.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	prio_reset_a: assert property ($rose(rstn) |-> q.prio == coax_pkg::PRIO_RST) // RULE13
		else $error("priority not at default after reset");
	prio_hold_a: assert property (!(wr && addr == coax_pkg::OFS_PRIO) |=> $stable(q.prio)) // RULE12
		else $error("priority changed without remote write");
	shr_mode_a: assert property (relay_shr != 4'h0
		|-> q.mode == coax_pkg::MD_SHR || $past(q.mode) == coax_pkg::MD_SHR) // RULE6
		else $error("shared input routed outside shared mode");
	mode_release_a: assert property (q.mode != $past(q.mode) |-> q.tgt == {4{coax_pkg::RT_PRI}} && !q.hv) // RULE15
		else $error("mode change kept a backup");
	green_led_a: assert property (led_green == {$past(rt.app[3]) == coax_pkg::RT_PRI,
		$past(rt.app[2]) == coax_pkg::RT_PRI, $past(rt.app[1]) == coax_pkg::RT_PRI,
		$past(rt.app[0]) == coax_pkg::RT_PRI}) // RULE8
		else $error("green indicator does not follow primary");
	red_led_a: assert property ($past(rt.app[0]) == coax_pkg::RT_DED |-> led_red[0]) // RULE9
		else $error("red indicator off on dedicated backup");
	err_beep_a: assert property ($rose(err_in) && q.beep_en |=> ##1 beeper [*8]) // RULE14
		else $error("beeper did not sound on error");
	pair_gang_a: assert property (q.mode == coax_pkg::MD_PAIR && wr && addr == coax_pkg::OFS_CMD
		&& wdata[1:0] == 2'b00 && wdata[coax_pkg::CMD_BKUP_BIT] && !key_ded_mode && !key_shr_mode
		&& key_normal == 4'h0 && key_backup == 4'h0
		|=> q.tgt[0] == coax_pkg::RT_DED && q.tgt[2] == coax_pkg::RT_DED) // RULE7
		else $error("paired command did not gang sections 1 and 3");
	shr_led_a: assert property ($past(|rt.rly_shr) |-> led_shared) // RULE10
		else $error("shared lamp off while shared input routed");
endmodule : coax_backup_switch
`default_nettype wire

// >>> tb/remote_model.sv
// Remote controller and front panel model driving the switch control inputs
`timescale 1ns/1ps
`default_nettype none
module remote_model (
	// Clock
	input  wire logic   clk,
	// Register port
	output logic [7:0]  addr,
	output logic [31:0] wdata,
	output logic        wr,
	output logic        rd,
	// Front panel and monitoring
	output logic [3:0]  key_normal,
	output logic [3:0]  key_backup,
	output logic        key_ded_mode,
	output logic        key_shr_mode,
	output logic        err_in
);
	// Expected read answers, oldest first
	logic [31:0] exp_q[$];

	// Idle at time zero
	initial
	begin
		{addr, wdata, wr, rd, key_normal, key_backup, key_ded_mode, key_shr_mode, err_in} = '0;
	end

	// One-cycle write; released lines show the inverse so stale data is never mistaken for valid
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask : wr_reg

	// One-cycle read; the answer is noted before the strobe goes out
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
	endtask : rd_reg

	// Key press: one-cycle pulse on the chosen keys
	task automatic press(input logic [3:0] n, input logic [3:0] b, input logic dm, input logic sm);
		@(posedge clk);
		{key_normal, key_backup, key_ded_mode, key_shr_mode} <= {n, b, dm, sm};
		@(posedge clk);
		{key_normal, key_backup, key_ded_mode, key_shr_mode} <= '0;
	endtask : press

	// Section command over the remote port
	task automatic cmd(input logic [1:0] s, input logic bkp);
		wr_reg(coax_pkg::OFS_CMD, {27'h000_0000, bkp, 2'b00, s});
	endtask : cmd

	// Priority order goes out only here; no key path can touch it
	task automatic set_prio(input logic [7:0] p);
		wr_reg(coax_pkg::OFS_PRIO, {24'h00_0000, p});
	endtask : set_prio

	// Monitoring error level
	task automatic set_err(input logic v);
		@(posedge clk);
		err_in <= v;
	endtask : set_err
endmodule : remote_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the coaxial backup switch control
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [3:0]  key_normal;
	logic [3:0]  key_backup;
	logic        key_ded_mode;
	logic        key_shr_mode;
	logic        err_in;
	logic [3:0]  relay_ded;
	logic [3:0]  relay_shr;
	logic [3:0]  term_primary;
	logic [3:0]  term_dedicated;
	logic        term_shared;
	logic [3:0]  led_green;
	logic [3:0]  led_red;
	logic        led_shared;
	logic        lamp_ded_key;
	logic        lamp_shr_key;
	logic        led_error;
	logic        beeper;
	logic        irq;
	logic        rd_seen;
	logic [31:0] seed;
	logic [3:0]  exp_ded;
	logic [1:0]  sec;
	int          err_count;
	int          compares;

	// Short ms tick keeps blink and beep counts small
	coax_backup_switch #(.TICK_CYCLES(4)) u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .key_normal(key_normal), .key_backup(key_backup), .key_ded_mode(key_ded_mode),
		.key_shr_mode(key_shr_mode), .err_in(err_in), .relay_ded(relay_ded), .relay_shr(relay_shr),
		.term_primary(term_primary), .term_dedicated(term_dedicated), .term_shared(term_shared),
		.led_green(led_green), .led_red(led_red), .led_shared(led_shared), .lamp_ded_key(lamp_ded_key),
		.lamp_shr_key(lamp_shr_key), .led_error(led_error), .beeper(beeper), .irq(irq));

	remote_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .key_normal(key_normal),
		.key_backup(key_backup), .key_ded_mode(key_ded_mode), .key_shr_mode(key_shr_mode), .err_in(err_in));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Let the edge's updates land before looking
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc

	// Read answers stand one cycle only, so they are taken on the edge after the strobe
	always @(posedge clk)
	begin
		if (rd_seen)
			check(rdata, u_host.exp_q.pop_front());
		rd_seen = rd;
		if (rstn === 1'b1)
		begin
			check(32'(relay_ded & relay_shr), 32'h0000_0000);
			check(32'($countones(relay_shr) > 1), 32'h0000_0000);
			check(32'({term_primary, term_dedicated, term_shared}),
				32'({relay_ded | relay_shr, ~relay_ded, ~|relay_shr}));
		end
	end

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		{err_count, compares, rd_seen} = '0;
		seed = 32'h0000_58eb;
		rstn = 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		wait_cyc(1);
		check(32'({relay_ded, relay_shr, led_green, lamp_ded_key}), 32'h0000_001f);
		u_host.rd_reg(coax_pkg::OFS_PRIO, 32'h0000_00e4);
		u_host.rd_reg({1'b1, seed[6:0]}, 32'h0000_0000);
		u_host.set_prio(8'h00);
		u_host.rd_reg(coax_pkg::OFS_PRIO, 32'h0000_00e4);
		u_host.set_prio(8'h1b);
		u_host.rd_reg(coax_pkg::OFS_PRIO, 32'h0000_001b);
		u_host.set_prio(8'he4);
		// Random dedicated traffic from keys and remote commands alike
		exp_ded = 4'h0;
		for (int i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			sec = seed[1:0];
			if (seed[3])
				u_host.press(seed[2] ? 4'h0 : 4'(1 << sec), seed[2] ? 4'(1 << sec) : 4'h0, 1'b0, 1'b0);
			else
				u_host.cmd(sec, seed[2]);
			exp_ded[sec] = seed[2];
			wait_cyc(4);
			check(32'({relay_ded, led_red, led_green}), 32'({exp_ded, exp_ded, ~exp_ded}));
		end
		// Paired mode gangs 1 with 3 and 2 with 4; a command to 4 acts alone
		u_host.press(4'h0, 4'h0, 1'b1, 1'b0);
		wait_cyc(4);
		check(32'(relay_ded), 32'h0000_0000);
		u_host.rd_reg(coax_pkg::OFS_CTRL, 32'h0000_0005);
		u_host.cmd(2'd0, 1'b1);
		wait_cyc(4);
		check(32'(relay_ded), 32'h0000_0005);
		u_host.cmd(2'd1, 1'b1);
		u_host.cmd(2'd3, 1'b0);
		wait_cyc(4);
		check(32'(relay_ded), 32'h0000_0007);
		u_host.wr_reg(coax_pkg::OFS_CTRL, 32'h0000_0004);
		wait_cyc(4);
		check(32'(relay_ded), 32'h0000_0000);
		// Shared mode: routing, preemption and refusal with the interrupt
		u_host.press(4'h0, 4'h0, 1'b0, 1'b1);
		u_host.wr_reg(coax_pkg::OFS_IRQS, 32'h0000_000f);
		u_host.press(4'h0, 4'h8, 1'b0, 1'b0);
		wait_cyc(4);
		check(32'({relay_shr, led_shared, term_primary, lamp_shr_key}), 32'h0000_0231);
		u_host.press(4'h0, 4'h1, 1'b0, 1'b0);
		wait_cyc(6);
		check(32'(relay_shr), 32'h0000_0001);
		u_host.rd_reg(coax_pkg::OFS_STAT, 32'h0000_0403);
		u_host.rd_reg(coax_pkg::OFS_IRQS, 32'h0000_0002);
		u_host.wr_reg(coax_pkg::OFS_IRQM, 32'h0000_0002);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0001);
		u_host.press(4'h0, 4'h4, 1'b0, 1'b0);
		wait_cyc(4);
		check(32'(relay_shr), 32'h0000_0001);
		u_host.rd_reg(coax_pkg::OFS_IRQS, 32'h0000_0006);
		u_host.wr_reg(coax_pkg::OFS_IRQS, 32'h0000_0006);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0000);
		u_host.press(4'h0, 4'h0, 1'b1, 1'b0);
		wait_cyc(4);
		check(32'({relay_shr, led_shared, term_shared}), 32'h0000_0001);
		// Error lamp always, beeper only when enabled
		for (int b = 0; b < 2; b++)
		begin
			u_host.wr_reg(coax_pkg::OFS_CTRL, 32'(b << 2));
			u_host.set_err(1'b1);
			wait_cyc(3);
			check(32'({led_error, beeper}), 32'({1'b1, b[0]}));
			u_host.set_err(1'b0);
			wait_cyc(3);
			check(32'(led_error), 32'h0000_0000);
		end
		end_sim();
	end
endmodule : tb
`default_nettype wire
